// ===== verilog/supply_fault_monitor.sv
// Purpose: Logic-supply and battery-supply fault monitor with latched
//          flags, driver shutdown and power-on comparator self-test.
// Assumes: Comparator outputs and host strobes are synchronous to CLK_I.
// Notes:   Flag registers are the read data; a read strobe clears them.
`include "supply_fault_defines.svh"

// Behaviour
// - Flag logic-supply under and over voltage.
// - Self-test logic-supply comparators after reset.
// - Logic-supply under voltage stops all drivers.
// - Under-voltage flag clears on read; host re-enables.
// - Logic-supply over voltage only reports.
// - Over-voltage flag clears on read.
// - Flag battery over voltage.
// - Self-test battery comparator after reset.
// - Battery over voltage stops drivers; host re-enables.
module supply_fault_monitor #(
  parameter int VDD_UV_FILT_CYC = `VDD_UV_FILT_CYC,
  parameter int VDD_OV_FILT_CYC = `VDD_OV_FILT_CYC,
  parameter int BAT_OV_FILT_CYC = `BAT_OV_FILT_CYC,
  parameter int ST_MARGIN_CYC   = `ST_MARGIN_CYC
) (
  input  wire logic                    CLK_I,
  input  wire logic                    ARST_N_I,
  input  wire logic                    CE_I,
  input  wire logic                    VDD_UV_CMP_I,
  input  wire logic                    VDD_OV_CMP_I,
  input  wire logic                    BAT_OV_CMP_I,
  input  wire logic                    READ_A_I,
  input  wire logic                    READ_B_I,
  input  wire logic                    SOL_EN_WR_I,
  input  wire logic                    FS_EN_WR_I,
  output logic [`FAULT_REG_W-1:0]      SERVICE_FAULT_A_O,
  output logic [`FAULT_REG_W-1:0]      SERVICE_FAULT_B_O,
  output logic                         SOL_EN_O,
  output logic                         FS_EN_O,
  output logic                         ST_FORCE_O,
  output logic                         ST_BUSY_O
);

  // The self-test waits for the slowest filter plus a margin, so a sound
  // channel always trips and releases before the timeout ends a phase.
  localparam int MAX_FILT =
    (VDD_UV_FILT_CYC > VDD_OV_FILT_CYC) ?
      ((VDD_UV_FILT_CYC > BAT_OV_FILT_CYC) ? VDD_UV_FILT_CYC
                                            : BAT_OV_FILT_CYC) :
      ((VDD_OV_FILT_CYC > BAT_OV_FILT_CYC) ? VDD_OV_FILT_CYC
                                            : BAT_OV_FILT_CYC);
  localparam int ST_TMO_CYC = MAX_FILT + ST_MARGIN_CYC;
  localparam int FILT_CYC [`CH_NUM] =
    '{VDD_UV_FILT_CYC, VDD_OV_FILT_CYC, BAT_OV_FILT_CYC};

  // Comparator, self-test, flag and enable state, in the order used below.
  supply_fault_pkg::cmp_vec_t        raw;
  supply_fault_pkg::cmp_vec_t        filt;
  supply_fault_pkg::selftest_state_e st_state;
  supply_fault_pkg::selftest_state_e next_st_state;
  supply_fault_pkg::cmp_vec_t        trip_ok;
  supply_fault_pkg::cmp_vec_t        next_trip_ok;
  supply_fault_pkg::cmp_vec_t        rel_ok;
  supply_fault_pkg::cmp_vec_t        next_rel_ok;
  logic [`TMR_W-1:0]                 tmr;
  logic [`TMR_W-1:0]                 next_tmr;
  logic                              st_end;
  logic [`FAULT_REG_W-1:0]           set_a;
  logic [`FAULT_REG_W-1:0]           set_b;
  logic [`FAULT_REG_W-1:0]           next_flags_a;
  logic [`FAULT_REG_W-1:0]           next_flags_b;
  logic                              shutdown;
  logic                              reenable_block;
  logic                              next_sol_en;
  logic                              next_fs_en;

  // Bit order of the comparator vector follows the channel indices.
  assign raw[`CH_VDD_UV] = VDD_UV_CMP_I;
  assign raw[`CH_VDD_OV] = VDD_OV_CMP_I;
  assign raw[`CH_BAT_OV] = BAT_OV_CMP_I;

  ////////////////////////////////////////////////////////////////////////////
  // One deglitch filter per comparator channel.
  // Each filter takes its own length from the table above.
  for (genvar ch = 0; ch < `CH_NUM; ch++) begin : g_filt
    supply_fault_filter #(
      .CNT_W    (`TMR_W),
      .FILT_CYC (FILT_CYC[ch])
    ) u_filt (
      .clk_i    (CLK_I),
      .arst_n_i (ARST_N_I),
      .ce_i     (CE_I),
      .raw_i    (raw[ch]),
      .level_o  (filt[ch])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Self-test: the comparators are forced to trip, then released. A
  // channel fails when it does not trip or does not release in time.
  // The timeout covers the longest filter so a healthy path always passes.
  always_comb begin
    // The timer counts within a phase and parks once the test has ended.
    next_st_state = st_state;
    next_trip_ok  = trip_ok;
    next_rel_ok   = rel_ok;
    next_tmr      = tmr + `TMR_W'(1);
    st_end        = 1'b0;
    unique case (st_state)
      supply_fault_pkg::ST_FORCE: begin
        next_trip_ok = trip_ok | filt;
        if (&next_trip_ok || tmr >= `TMR_W'(ST_TMO_CYC)) begin
          next_st_state = supply_fault_pkg::ST_RELEASE;
          next_tmr      = '0;
        end
      end
      supply_fault_pkg::ST_RELEASE: begin
        next_rel_ok = ~filt;
        if (~|filt || tmr >= `TMR_W'(ST_TMO_CYC)) begin
          next_st_state = supply_fault_pkg::ST_DONE;
          st_end        = 1'b1;
        end
      end
      supply_fault_pkg::ST_DONE: begin
        next_tmr = tmr;
      end
      default: begin
        next_st_state = supply_fault_pkg::ST_DONE;
        next_tmr      = tmr;
      end
    endcase
  end

  // Self-test registers; the test starts on every reset release.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      st_state <= supply_fault_pkg::ST_FORCE;
      trip_ok  <= '0;
      rel_ok   <= '0;
      tmr      <= '0;
    end else if (CE_I) begin
      st_state <= next_st_state;
      trip_ok  <= next_trip_ok;
      rel_ok   <= next_rel_ok;
      tmr      <= next_tmr;
    end
  end

  // Status outputs decode the state register, so they carry no glitches
  // from the next-state logic.
  assign ST_BUSY_O  = (st_state != supply_fault_pkg::ST_DONE);
  assign ST_FORCE_O = (st_state == supply_fault_pkg::ST_FORCE);

  ////////////////////////////////////////////////////////////////////////////
  // Sticky flags. Live faults are ignored while the self-test forces and
  // releases the comparators, since they would only report the test itself. Set wins
  // over the clear of the same cycle, so a fault that persists across a
  // read shows again at once.
  // Reserved bits are never set, so they always read back as zero.
  always_comb begin
    set_a = '0;
    set_b = '0;
    set_a[`A_VDD_UV_BIT] = filt[`CH_VDD_UV] & ~ST_BUSY_O;
    set_a[`A_VDD_OV_BIT] = filt[`CH_VDD_OV] & ~ST_BUSY_O;
    set_a[`A_BAT_OV_BIT] = filt[`CH_BAT_OV] & ~ST_BUSY_O;
    set_b[`B_VDD_UV_ST_BIT] = st_end &
      ~(next_trip_ok[`CH_VDD_UV] & next_rel_ok[`CH_VDD_UV]);
    set_b[`B_VDD_OV_ST_BIT] = st_end &
      ~(next_trip_ok[`CH_VDD_OV] & next_rel_ok[`CH_VDD_OV]);
    set_b[`B_BAT_OV_ST_BIT] = st_end &
      ~(next_trip_ok[`CH_BAT_OV] & next_rel_ok[`CH_BAT_OV]);
    next_flags_a = (SERVICE_FAULT_A_O & ~{`FAULT_REG_W{READ_A_I}})
                   | set_a;
    next_flags_b = (SERVICE_FAULT_B_O & ~{`FAULT_REG_W{READ_B_I}})
                   | set_b;
  end

  // Flag registers double as the read data seen by the host.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      SERVICE_FAULT_A_O <= `FAULT_REG_RST;
      SERVICE_FAULT_B_O <= `FAULT_REG_RST;
    end else if (CE_I) begin
      SERVICE_FAULT_A_O <= next_flags_a;
      SERVICE_FAULT_B_O <= next_flags_b;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Driver enables. Only under voltage and battery over voltage shut the
  // drivers down; logic over voltage is left out on purpose. A re-enable
  // is refused while a shutdown flag is still latched or the fault stands,
  // so the host must read the flags first and then write again.
  always_comb begin
    shutdown = set_a[`A_VDD_UV_BIT] | set_a[`A_BAT_OV_BIT];
    reenable_block = ST_BUSY_O | shutdown
                     | SERVICE_FAULT_A_O[`A_VDD_UV_BIT]
                     | SERVICE_FAULT_A_O[`A_BAT_OV_BIT];
    next_sol_en = SOL_EN_O;
    next_fs_en  = FS_EN_O;
    if (shutdown) begin
      next_sol_en = 1'b0;
      next_fs_en  = 1'b0;
    end else if (!reenable_block) begin
      next_sol_en = SOL_EN_O | SOL_EN_WR_I;
      next_fs_en  = FS_EN_O | FS_EN_WR_I;
    end
  end

  // Enables come up off after reset, as after any power-on.
  // A low clock enable holds them, so a frozen block neither shuts the
  // drivers down nor lets a write through.
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      SOL_EN_O <= 1'b0;
      FS_EN_O  <= 1'b0;
    end else if (CE_I) begin
      SOL_EN_O <= next_sol_en;
      FS_EN_O  <= next_fs_en;
    end
  end

endmodule // supply_fault_monitor

// ===== inc/supply_fault_defines.svh
// Purpose: Constants of the supply-fault monitor: flag positions, widths,
//          reset values and filter timing.
// Assumes: System clock of 250 MHz.
// Notes:   Times are in ns; cycle counts are derived from them.
`ifndef SUPPLY_FAULT_DEFINES_SVH
`define SUPPLY_FAULT_DEFINES_SVH

`define CLK_MHZ          250
`define FAULT_REG_W      16
`define FAULT_REG_RST    16'h0000

// Flag positions in service_fault_reg_a.
`define A_BAT_OV_BIT     1
`define A_VDD_UV_BIT     4
`define A_VDD_OV_BIT     5

// Flag positions in service_fault_reg_b (self-test failures).
`define B_BAT_OV_ST_BIT  4
`define B_VDD_UV_ST_BIT  6
`define B_VDD_OV_ST_BIT  7

// Comparator channel indices.
`define CH_VDD_UV        0
`define CH_VDD_OV        1
`define CH_BAT_OV        2
`define CH_NUM           3

// Least deglitch times, rounded up to whole cycles.
`define VDD_UV_FILT_NS   9000
`define VDD_OV_FILT_NS   90000
`define BAT_OV_FILT_NS   90000
`define NS_TO_CYC(ns)    (((ns) * `CLK_MHZ + 999) / 1000)
`define VDD_UV_FILT_CYC  `NS_TO_CYC(`VDD_UV_FILT_NS)
`define VDD_OV_FILT_CYC  `NS_TO_CYC(`VDD_OV_FILT_NS)
`define BAT_OV_FILT_CYC  `NS_TO_CYC(`BAT_OV_FILT_NS)

// Extra wait granted to each self-test phase beyond the longest filter.
`define ST_MARGIN_CYC    64
`define TMR_W            18

`endif

// ===== inc/supply_fault_pkg.sv
// Purpose: Types shared by the supply-fault monitor files.
// Assumes: Nothing beyond the defines header.
// Notes:   Constants live in supply_fault_defines.svh.
package supply_fault_pkg;

  // Power-on comparator self-test sequence.
  typedef enum logic [1:0] {
    ST_FORCE   = 2'b00,
    ST_RELEASE = 2'b01,
    ST_DONE    = 2'b10
  } selftest_state_e;

  typedef logic [2:0] cmp_vec_t;

endpackage

// ===== verilog/supply_fault_filter.sv
// Purpose: Digital deglitch filter for one supply comparator.
// Assumes: Comparator input is synchronous to the clock.
// Notes:   Output changes only after the input held the new level
//          for FILT_CYC consecutive enabled cycles.
module supply_fault_filter #(
  parameter int CNT_W    = 18,
  parameter int FILT_CYC = 2250
) (
  input  wire logic clk_i,
  input  wire logic arst_n_i,
  input  wire logic ce_i,
  input  wire logic raw_i,
  output logic      level_o
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             next_level;

  ////////////////////////////////////////////////////////////////////////////
  // A return to the output level restarts the count, so short spikes never reach the flags.
  always_comb begin
    next_cnt   = '0;
    next_level = level_o;
    if (raw_i != level_o) begin
      if (cnt >= CNT_W'(FILT_CYC - 1)) begin
        next_level = raw_i;
      end else begin
        next_cnt = cnt + CNT_W'(1);
      end
    end
  end

  // State registers, frozen while the clock enable is low.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt     <= '0;
      level_o <= 1'b0;
    end else if (ce_i) begin
      cnt     <= next_cnt;
      level_o <= next_level;
    end
  end

endmodule // supply_fault_filter

// ===== tb/supply_fault_checker.sv
// Purpose: Port assertions for the supply-fault monitor.
// Assumes: CE_I low freezes the run counters as it freezes the block.
// Notes:   Filter lengths arrive through the bind below.
`include "supply_fault_defines.svh"
module supply_fault_checker #(
  parameter int VDD_UV_FILT_CYC = 4,
  parameter int VDD_OV_FILT_CYC = 8,
  parameter int BAT_OV_FILT_CYC = 8
) (
  input wire logic        CLK_I,
  input wire logic        ARST_N_I,
  input wire logic        CE_I,
  input wire logic        VDD_UV_CMP_I,
  input wire logic        VDD_OV_CMP_I,
  input wire logic        BAT_OV_CMP_I,
  input wire logic        READ_B_I,
  input wire logic        SOL_EN_WR_I,
  input wire logic [15:0] SERVICE_FAULT_A_O,
  input wire logic [15:0] SERVICE_FAULT_B_O,
  input wire logic        SOL_EN_O,
  input wire logic        FS_EN_O,
  input wire logic        ST_BUSY_O
);
////////////////////////////////////////////////////////////////////////////
  timeunit 1ns;
  timeprecision 1ps;
  // Run length of each comparator; it saturates so a long fault never wraps.
  // It holds while CE_I is low, since the filters hold then as well.
  logic [7:0]                 run [3];
  logic [7:0]                 next_run [3];
  supply_fault_pkg::cmp_vec_t cmp;
  wire [15:0]                 fa = SERVICE_FAULT_A_O;
  assign cmp = {BAT_OV_CMP_I, VDD_OV_CMP_I, VDD_UV_CMP_I};
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      if (!CE_I) begin
        next_run[i] = run[i];
      end else if (!cmp[i]) begin
        next_run[i] = 8'h00;
      end else begin
        next_run[i] = run[i] + {7'h00, run[i] != 8'hFF};
      end
    end
  end
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) run <= '{default: 8'h00};
    else run <= next_run;
  end
////////////////////////////////////////////////////////////////////////////
  // All checks share one clock and the one reset.
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!ARST_N_I);
  sequence s_drv_off;
    (!SOL_EN_O && !FS_EN_O) [*2];
  endsequence
  a_uv_flag_set: assert property (
    run[0] == VDD_UV_FILT_CYC + 1 && !ST_BUSY_O |-> ##[0:2] fa[`A_VDD_UV_BIT])
    else $error("uv flag late");
  a_ov_flag_set: assert property (
    run[1] == VDD_OV_FILT_CYC + 1 && !ST_BUSY_O |-> ##[0:2] fa[`A_VDD_OV_BIT])
    else $error("ov flag late");
  a_bat_flag_set: assert property (
    run[2] == BAT_OV_FILT_CYC + 1 && !ST_BUSY_O |-> ##[0:2] fa[`A_BAT_OV_BIT])
    else $error("bat flag late");
  a_uv_deglitch: assert property (
    $rose(fa[`A_VDD_UV_BIT]) |-> $past(run[0], 2) >= VDD_UV_FILT_CYC - 1)
    else $error("uv glitch");
  a_uv_drv_off: assert property (
    fa[`A_VDD_UV_BIT] |-> s_drv_off)
    else $error("uv left drivers on");
  a_bat_drv_off: assert property (
    fa[`A_BAT_OV_BIT] |-> s_drv_off)
    else $error("bat left drivers on");
  a_off_cause: assert property (
    $fell(SOL_EN_O) || $fell(FS_EN_O)
      |-> fa[`A_VDD_UV_BIT] || fa[`A_BAT_OV_BIT])
    else $error("stray off");
  a_en_cause: assert property (
    $rose(SOL_EN_O) |-> $past(SOL_EN_WR_I) && !$past(ST_BUSY_O))
    else $error("stray on");
  a_b_read_clr: assert property (
    READ_B_I && CE_I && !ST_BUSY_O |=> SERVICE_FAULT_B_O == 16'h0000)
    else $error("b not cleared");
  a_spare_zero: assert property (
    (fa & ~16'h0032) == 16'h0000
      && (SERVICE_FAULT_B_O & ~16'h00D0) == 16'h0000)
    else $error("spare set");
endmodule // supply_fault_checker

bind supply_fault_monitor supply_fault_checker #(
  .VDD_UV_FILT_CYC   (VDD_UV_FILT_CYC),
  .VDD_OV_FILT_CYC   (VDD_OV_FILT_CYC),
  .BAT_OV_FILT_CYC   (BAT_OV_FILT_CYC)
) u_checker (
  .CLK_I             (CLK_I),
  .ARST_N_I          (ARST_N_I),
  .CE_I              (CE_I),
  .VDD_UV_CMP_I      (VDD_UV_CMP_I),
  .VDD_OV_CMP_I      (VDD_OV_CMP_I),
  .BAT_OV_CMP_I      (BAT_OV_CMP_I),
  .READ_B_I          (READ_B_I),
  .SOL_EN_WR_I       (SOL_EN_WR_I),
  .SERVICE_FAULT_A_O (SERVICE_FAULT_A_O),
  .SERVICE_FAULT_B_O (SERVICE_FAULT_B_O),
  .SOL_EN_O          (SOL_EN_O),
  .FS_EN_O           (FS_EN_O),
  .ST_BUSY_O         (ST_BUSY_O)
);

// ===== tb/supply_env_model.sv
// Purpose: Comparator front end seen by the monitor.
// Assumes: Index 0 under voltage, 1 over voltage, 2 battery.
// Notes:   A channel not marked good ignores the self-test force.
module supply_env_model (
  input wire logic       clk_i,
  input wire logic       force_i,
  input wire logic [2:0] fault_i,
  input wire logic [2:0] good_i,
  output logic     [2:0] cmp_o = 3'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Changing on the falling edge keeps the monitor's sampling race free.
  always @(negedge clk_i) cmp_o <= fault_i | ({3{force_i}} & good_i);
endmodule // supply_env_model

// ===== tb/supply_fault_monitor_tb.sv
// Purpose: Self-checking bench for the supply-fault monitor.
// Assumes: Short filters of 4, 8 and 8 cycles.
// Notes:   The host side is played by the tasks below.
module supply_fault_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk = 1'b0, rst_n = 1'b0, rd_a = 1'b0, rd_b = 1'b0, ce = 1'b1;
  logic [1:0] wr = 2'h0;
  logic [2:0] fault = 3'h0, good = 3'h0;
  logic [15:0] e;
  wire [2:0]  cmp;
  wire [15:0] fa, fb;
  wire        sol, fs, frc, busy;
  wire [15:0] drv = {14'h0000, sol, fs};
  int         n_mismatch = 0, cmp_count = 0;
////////////////////////////////////////////////////////////////////////////
  initial forever #2 clk = ~clk;
  supply_env_model model (.clk_i(clk), .force_i(frc), .fault_i(fault),
    .good_i(good), .cmp_o(cmp));
  supply_fault_monitor #(.VDD_UV_FILT_CYC(4), .VDD_OV_FILT_CYC(8),
    .BAT_OV_FILT_CYC(8), .ST_MARGIN_CYC(4)) dut (
    .CLK_I(clk), .ARST_N_I(rst_n), .CE_I(ce),
    .VDD_UV_CMP_I(cmp[0]), .VDD_OV_CMP_I(cmp[1]), .BAT_OV_CMP_I(cmp[2]),
    .READ_A_I(rd_a), .READ_B_I(rd_b), .SOL_EN_WR_I(wr[1]),
    .FS_EN_WR_I(wr[0]),
    .SERVICE_FAULT_A_O(fa), .SERVICE_FAULT_B_O(fb), .SOL_EN_O(sol),
    .FS_EN_O(fs), .ST_FORCE_O(frc), .ST_BUSY_O(busy));
////////////////////////////////////////////////////////////////////////////
  // Host-side helpers; every strobe is one cycle wide with a gap after it.
  task automatic tick(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(string nm, logic [15:0] x, logic [15:0] g);
    cmp_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask
  // The read value is the one shown while the strobe is high.
  task automatic rd(bit b, logic [15:0] x);
    if (b) rd_b = 1'b1;
    else rd_a = 1'b1;
    chk(b ? "reg_b" : "reg_a", x, b ? fb : fa);
    tick(1);
    rd_a = 1'b0;
    rd_b = 1'b0;
    tick(1);
  endtask
  // Bit 1 writes the solenoid enable, bit 0 the fail-safe enable.
  task automatic wr_en(logic [1:0] m);
    wr = m;
    tick(1);
    wr = 2'h0;
    tick(1);
  endtask
  // A second reset in mid-run is fine; the self-test must end in bound.
  task automatic boot(logic [2:0] h);
    rst_n = 1'b0;
    good = h;
    tick(6);
    rst_n = 1'b1;
    for (int i = 0; i < 200 && busy !== 1'b0; i++) tick(1);
    chk("st_status", 16'h0000, {14'h0000, frc, busy});
    if (busy !== 1'b0) final_report();
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
////////////////////////////////////////////////////////////////////////////
  // Self-test failure and pass, then each supply fault in turn.
  initial begin
    boot(3'h0);
    chk("reg_b", 16'h00D0, fb);
    chk("drv", 16'h0000, drv);
    rd(1, 16'h00D0);
    chk("reg_b", 16'h0000, fb);
    $display("test selftest_fail done");
    boot(3'h7);
    chk("reg_b", 16'h0000, fb);
    wr_en(2'h2);
    chk("drv", 16'h0002, drv);
    wr_en(2'h1);
    chk("drv", 16'h0003, drv);
    fault <= 3'h2;
    tick(14);
    chk("reg_a", 16'h0020, fa);
    chk("drv", 16'h0003, drv);
    fault <= 3'h0;
    tick(14);
    rd(0, 16'h0020);
    chk("reg_a", 16'h0000, fa);
    chk("drv", 16'h0003, drv);
    $display("test vdd_ov done");
    for (int c = 0; c < 3; c += 2) begin
      e = (c == 0) ? 16'h0010 : 16'h0002;
      fault <= 3'h1 << c;
      tick(14);
      chk("reg_a", e, fa);
      chk("drv", 16'h0000, drv);
      rd(0, e);
      chk("reg_a", e, fa);
      wr_en(2'h3);
      chk("drv", 16'h0000, drv);
      fault <= 3'h0;
      tick(14);
      chk("reg_a", e, fa);
      rd(0, e);
      chk("reg_a", 16'h0000, fa);
      wr_en(2'h3);
      chk("drv", 16'h0003, drv);
      $display("test shutdown %0d done", c);
    end
    // A low clock enable holds filters and flags while a fault stands.
    ce = 1'b0;
    fault <= 3'h1;
    tick(14);
    chk("reg_a", 16'h0000, fa);
    chk("drv", 16'h0003, drv);
    ce = 1'b1;
    tick(14);
    chk("reg_a", 16'h0010, fa);
    chk("drv", 16'h0000, drv);
    fault <= 3'h0;
    tick(14);
    rd(0, 16'h0010);
    chk("reg_a", 16'h0000, fa);
    $display("test clock_enable done");
    final_report();
  end
endmodule // supply_fault_monitor_tb
